/* pkg/otp_seq_pkg.sv */
// constants, register map and state encoding for the fuse programming sequencer
package otp_seq_pkg;

  // clock and timing
  localparam int CLK_MHZ      = 100;            // system clock rate
  localparam int BURN_TMO_US  = 10000;          // completion poll limit, microseconds
  localparam int BURN_TMO_CYC = BURN_TMO_US * CLK_MHZ; // same limit in clock cycles

  // sensor register addresses (14-bit address space)
  localparam logic [13:0] DEV_IMG_BASE  = 14'h0015; // first location of settings image
  localparam logic [13:0] DEV_PROG      = 14'h0003; // program control register
  localparam logic [13:0] DEV_ANGLE     = 14'h3fff; // compensated_angle register
  localparam logic [13:0] DEV_KEY       = 14'h3fd0; // ecc_key_readout
  localparam logic [13:0] DEV_ZHI       = 14'h0016; // zero_position_high
  localparam logic [13:0] DEV_ZLO       = 14'h0017; // zero_position_low
  localparam logic [13:0] DEV_CFG_A     = 14'h0018; // config_reg_a
  localparam logic [13:0] DEV_CFG_B     = 14'h0019; // config_reg_b
  localparam logic [13:0] DEV_CFG_C     = 14'h001a; // config_reg_c
  localparam logic [13:0] DEV_ECC       = 14'h001b; // protection register

  // offsets inside the image window
  localparam logic [2:0] IDX_FIRST     = 3'h0; // 0x0015
  localparam logic [2:0] IDX_PWR_FIRST = 3'h1; // 0x0016, power-on check start
  localparam logic [2:0] IDX_RNG_LAST  = 3'h5; // 0x001a, pre-protection readback end
  localparam logic [2:0] IDX_LAST      = 3'h6; // 0x001b

  // program control bits and completion value
  localparam int          PROG_EN_BIT  = 0; // program_access_enable
  localparam int          PROG_REF_BIT = 2; // fuse_refresh
  localparam int          PROG_BRN_BIT = 3; // burn_trigger
  localparam int          PROG_VER_BIT = 6; // guard_band_verify
  localparam logic [15:0] PROG_DONE    = 16'h0001;

  // protection register layout
  localparam int          ECC_EN_BIT   = 7;
  localparam logic [7:0]  ECC_KEY_MASK = 8'h7f;

  // our own register map on apb
  localparam logic [7:0] REG_CTRL   = 8'h00; // start, resume, dual die
  localparam logic [7:0] REG_CFG    = 8'h04; // three settings bytes
  localparam logic [7:0] REG_STAT   = 8'h08; // sequencer status
  localparam logic [7:0] REG_ANGLE  = 8'h0c; // captured zero angle
  localparam int         CTRL_START  = 0;
  localparam int         CTRL_RESUME = 1;
  localparam int         CTRL_DUAL   = 2;
  localparam logic [23:0] CFG_RST    = 24'h000000;

  // sequencer states
  typedef enum logic [4:0] {
    S_IDLE, S_PWR1, S_WCFG, S_RANG, S_WZLO, S_WZHI, S_RD1, S_WEN1, S_RKEY,
    S_WKEY, S_WEN2, S_CHK1, S_WPEN, S_WBRN, S_POLL, S_CLR, S_WVER, S_WREF,
    S_CHK2, S_PWR2, S_CHK3, S_DONE, S_FAIL
  } seq_state_e;

endpackage

/* logic/otp_seq_host.sv */
// host sequencer that burns and verifies the sensor's fuse settings
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module otp_seq_host
  import otp_seq_pkg::*;
#(
  parameter int BURN_TMO = BURN_TMO_CYC // completion poll limit in cycles
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // apb slave, our own registers
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // sensor register access port
  output logic             dev_req,
  output logic             dev_we,
  output logic [13:0]      dev_addr,
  output logic [7:0]       dev_wdata,
  input  wire logic [15:0] dev_rdata,
  input  wire logic        dev_ack,
  // system side
  output logic             power_cycle_req,
  output logic             die_sel,
  output logic             part_rejected
);

  localparam int TW = $clog2(BURN_TMO + 1);

  if (BURN_TMO < 1) begin : g_chk
    $error("BURN_TMO must be at least one cycle");
  end

  // state
  seq_state_e  st_r, st_nxt;                // sequencer state
  logic [2:0]  idx_r, idx_nxt;              // step index inside a range
  logic        req_r, req_nxt;              // outstanding sensor access
  logic        we_r, we_nxt;
  logic [13:0] addr_r, addr_nxt;
  logic [7:0]  wd_r, wd_nxt;
  logic [13:0] ang_r, ang_nxt;              // captured zero angle
  logic [7:0]  key_r, key_nxt;              // correction key
  logic [7:0]  img_r [0:6];                 // expected image 0x0015..0x001b
  logic [7:0]  img_nxt [0:6];
  logic [TW-1:0] tmo_r, tmo_nxt;            // poll timer
  logic        chk1_ok_r, chk1_ok_nxt;      // pre-burn compare passed
  logic        pen_r, pen_nxt;              // program access enabled
  logic        burned_r, burned_nxt;        // burn reported complete
  logic        ver_r, ver_nxt;              // guard band armed
  logic        rej_r, rej_nxt;              // sticky reject
  logic        tmo_flag_r, tmo_flag_nxt;    // timeout seen
  logic        die_r, die_nxt;
  logic        dual_r, dual_nxt;
  logic [23:0] cfg_r, cfg_nxt;              // settings bytes from software

  // operation wanted by the current state
  logic        op_we;
  logic [13:0] op_addr;
  logic [7:0]  op_data;
  logic        ok_byte;                     // read byte equals expectation
  logic        wr_acc, start_wr, resume_wr;

  // apb decode; zero wait states
  assign pready    = 1'b1;
  assign wr_acc    = psel && penable && pwrite;
  assign start_wr  = wr_acc && (paddr == REG_CTRL) && pwdata[CTRL_START];
  assign resume_wr = wr_acc && (paddr == REG_CTRL) && pwdata[CTRL_RESUME];
  assign ok_byte   = (dev_rdata[7:0] == img_r[idx_r]);

  // read mux; unmapped offsets answer with an error
  always_comb begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    unique case (paddr)
      REG_CTRL:  prdata = {29'h0, dual_r, 2'b00};
      REG_CFG:   prdata = {8'h00, cfg_r};
      REG_STAT:  prdata = {20'h0, st_r, die_r, tmo_flag_r, rej_r,
                           st_r == S_FAIL, st_r == S_DONE,
                           power_cycle_req, st_r != S_IDLE && st_r != S_DONE
                           && st_r != S_FAIL};
      REG_ANGLE: prdata = {18'h0, ang_r};
      default:   pslverr = psel && penable;
    endcase
  end

  // what each state asks of the sensor
  always_comb begin
    op_we   = 1'b1;
    op_addr = DEV_IMG_BASE + {11'h0, idx_r};
    op_data = 8'h00;
    unique case (st_r)
      S_WCFG: begin
        op_addr = (idx_r == 3'h0) ? DEV_CFG_A : (idx_r == 3'h1) ? DEV_CFG_B : DEV_CFG_C;
        op_data = cfg_r[{idx_r[1:0], 3'b000} +: 8];
      end
      S_RANG: begin
        op_we   = 1'b0;
        op_addr = DEV_ANGLE;
      end
      S_WZLO: begin
        op_addr = DEV_ZLO;
        op_data = {2'b00, ang_r[5:0]};
      end
      S_WZHI: begin
        op_addr = DEV_ZHI;
        op_data = ang_r[13:6];
      end
      S_WEN1: begin
        op_addr = DEV_ECC;
        op_data = 8'h01 << ECC_EN_BIT;
      end
      S_RKEY: begin
        op_we   = 1'b0;
        op_addr = DEV_KEY;
      end
      S_WKEY, S_WEN2: begin
        op_addr = DEV_ECC;
        op_data = (key_r & ECC_KEY_MASK) | (8'h01 << ECC_EN_BIT);
      end
      S_WPEN: begin
        op_addr = DEV_PROG;
        op_data = 8'h01 << PROG_EN_BIT;
      end
      S_WBRN: begin
        op_addr = DEV_PROG;
        op_data = (8'h01 << PROG_EN_BIT) | (8'h01 << PROG_BRN_BIT);
      end
      S_POLL: begin
        op_we   = 1'b0;
        op_addr = DEV_PROG;
      end
      S_WVER: begin
        op_addr = DEV_PROG;
        op_data = 8'h01 << PROG_VER_BIT;
      end
      S_WREF: begin
        op_addr = DEV_PROG;
        op_data = (8'h01 << PROG_VER_BIT) | (8'h01 << PROG_REF_BIT);
      end
      S_RD1, S_CHK1, S_CHK2, S_CHK3: op_we = 1'b0; // range readbacks
      default: op_we = 1'b1; // S_CLR writes zero across the image
    endcase
  end

  // sequencer next values
  always_comb begin
    st_nxt = st_r; idx_nxt = idx_r; req_nxt = req_r; we_nxt = we_r;
    addr_nxt = addr_r; wd_nxt = wd_r; ang_nxt = ang_r; key_nxt = key_r;
    img_nxt = img_r; tmo_nxt = tmo_r; chk1_ok_nxt = chk1_ok_r; pen_nxt = pen_r;
    burned_nxt = burned_r; ver_nxt = ver_r; rej_nxt = rej_r;
    tmo_flag_nxt = tmo_flag_r; die_nxt = die_r; dual_nxt = dual_r; cfg_nxt = cfg_r;
    // software writes
    if (wr_acc && paddr == REG_CFG) cfg_nxt = pwdata[23:0];
    if (wr_acc && paddr == REG_CTRL && st_r == S_IDLE) dual_nxt = pwdata[CTRL_DUAL];
    unique case (st_r)
      S_IDLE, S_DONE, S_FAIL: begin
        // a rejected part never gets another run
        if (start_wr && !rej_r) begin
          st_nxt = S_PWR1; die_nxt = 1'b0; tmo_flag_nxt = 1'b0;
          chk1_ok_nxt = 1'b0; pen_nxt = 1'b0; burned_nxt = 1'b0; ver_nxt = 1'b0;
        end
      end
      S_PWR1: if (resume_wr) begin
        st_nxt = S_WCFG; idx_nxt = IDX_FIRST;
      end
      S_PWR2: if (resume_wr) begin
        st_nxt = S_CHK3; idx_nxt = IDX_PWR_FIRST;
      end
      default: begin
        if (st_r == S_POLL && tmo_r != TW'(BURN_TMO)) tmo_nxt = tmo_r + TW'(1);
        if (!req_r) begin
          // launch the access; held stable until acknowledged
          req_nxt = 1'b1; we_nxt = op_we; addr_nxt = op_addr; wd_nxt = op_data;
        end else if (dev_ack) begin
          req_nxt = 1'b0;
          // track what is written into the image window, except the clear
          if (we_r && st_r != S_CLR && addr_r >= DEV_IMG_BASE && addr_r <= DEV_ECC)
            img_nxt[3'(addr_r - DEV_IMG_BASE)] = wd_r;
          unique case (st_r)
            S_WCFG: if (idx_r == 3'h2) st_nxt = S_RANG; else idx_nxt = idx_r + 3'h1;
            S_RANG: begin
              ang_nxt = dev_rdata[13:0]; st_nxt = S_WZLO;
            end
            S_WZLO: st_nxt = S_WZHI;
            S_WZHI: begin
              st_nxt = S_RD1; idx_nxt = IDX_FIRST;
            end
            S_RD1: begin
              if (idx_r == IDX_FIRST) img_nxt[0] = dev_rdata[7:0];
              if (idx_r == IDX_RNG_LAST) st_nxt = S_WEN1; else idx_nxt = idx_r + 3'h1;
            end
            S_WEN1: st_nxt = S_RKEY;
            S_RKEY: begin
              key_nxt = dev_rdata[7:0]; st_nxt = S_WKEY;
            end
            S_WKEY: st_nxt = S_WEN2;
            S_WEN2: begin
              st_nxt = S_CHK1; idx_nxt = IDX_FIRST;
            end
            S_CHK1: begin
              if (!ok_byte) st_nxt = S_FAIL;
              else if (idx_r == IDX_LAST) begin
                st_nxt = S_WPEN; chk1_ok_nxt = 1'b1;
              end else idx_nxt = idx_r + 3'h1;
            end
            S_WPEN: begin
              st_nxt = S_WBRN; pen_nxt = 1'b1;
            end
            S_WBRN: begin
              st_nxt = S_POLL; tmo_nxt = '0;
            end
            S_POLL: begin
              if (dev_rdata == PROG_DONE) begin
                st_nxt = S_CLR; idx_nxt = IDX_FIRST; burned_nxt = 1'b1;
              end else if (tmo_r == TW'(BURN_TMO)) begin
                st_nxt = S_FAIL; tmo_flag_nxt = 1'b1; rej_nxt = 1'b1;
              end
            end
            S_CLR: begin
              if (idx_r == IDX_LAST) st_nxt = S_WVER; else idx_nxt = idx_r + 3'h1;
            end
            S_WVER: begin
              st_nxt = S_WREF; ver_nxt = 1'b1;
            end
            S_WREF: begin
              st_nxt = S_CHK2; idx_nxt = IDX_FIRST;
            end
            S_CHK2: begin
              if (!ok_byte) begin
                st_nxt = S_FAIL; rej_nxt = 1'b1;
              end else if (idx_r == IDX_LAST) st_nxt = S_PWR2;
              else idx_nxt = idx_r + 3'h1;
            end
            S_CHK3: begin
              if (!ok_byte) begin
                st_nxt = S_FAIL; rej_nxt = 1'b1;
              end else if (idx_r != IDX_LAST) idx_nxt = idx_r + 3'h1;
              else if (dual_r && !die_r) begin
                st_nxt = S_PWR1; die_nxt = 1'b1; chk1_ok_nxt = 1'b0;
                pen_nxt = 1'b0; burned_nxt = 1'b0; ver_nxt = 1'b0;
              end else st_nxt = S_DONE;
            end
            default: st_nxt = S_FAIL;
          endcase
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= S_IDLE; idx_r <= 3'h0; req_r <= 1'b0; we_r <= 1'b0;
      addr_r <= 14'h0000; wd_r <= 8'h00; ang_r <= 14'h0000; key_r <= 8'h00;
      for (int i = 0; i < 7; i++) img_r[i] <= 8'h00;
      tmo_r <= '0; chk1_ok_r <= 1'b0; pen_r <= 1'b0; burned_r <= 1'b0;
      ver_r <= 1'b0; rej_r <= 1'b0; tmo_flag_r <= 1'b0; die_r <= 1'b0;
      dual_r <= 1'b0; cfg_r <= CFG_RST;
    end else begin
      st_r <= st_nxt; idx_r <= idx_nxt; req_r <= req_nxt; we_r <= we_nxt;
      addr_r <= addr_nxt; wd_r <= wd_nxt; ang_r <= ang_nxt; key_r <= key_nxt;
      img_r <= img_nxt; tmo_r <= tmo_nxt; chk1_ok_r <= chk1_ok_nxt;
      pen_r <= pen_nxt; burned_r <= burned_nxt; ver_r <= ver_nxt; rej_r <= rej_nxt;
      tmo_flag_r <= tmo_flag_nxt; die_r <= die_nxt; dual_r <= dual_nxt; cfg_r <= cfg_nxt;
    end
  end

  // outputs
  assign dev_req         = req_r;
  assign dev_we          = we_r;
  assign dev_addr        = addr_r;
  assign dev_wdata       = wd_r;
  assign die_sel         = die_r;
  assign part_rejected   = rej_r;
  assign power_cycle_req = (st_r == S_PWR1) || (st_r == S_PWR2);

  // checks
  logic burn_wr, ver_wr, ref_wr;
  assign burn_wr = req_r && we_r && addr_r == DEV_PROG && wd_r[PROG_BRN_BIT];
  assign ver_wr  = req_r && we_r && addr_r == DEV_PROG && wd_r[PROG_VER_BIT];
  assign ref_wr  = req_r && we_r && addr_r == DEV_PROG && wd_r[PROG_REF_BIT];

  a_burn_verified: assert property (@(posedge clock) disable iff (srst)
    burn_wr |-> chk1_ok_r) else $error("burn issued without clean readback");
  a_burn_enabled: assert property (@(posedge clock) disable iff (srst)
    burn_wr |-> pen_r && wd_r[PROG_EN_BIT]) else $error("burn before access enable");
  a_burn_once: assert property (@(posedge clock) disable iff (srst)
    $rose(burn_wr) |-> $past(st_r) == S_WBRN) else $error("burn trigger out of order");
  a_poll_exit: assert property (@(posedge clock) disable iff (srst)
    st_r == S_POLL && req_r && dev_ack && dev_rdata == PROG_DONE |=> st_r == S_CLR)
    else $error("completion not taken");
  a_no_reburn: assert property (@(posedge clock) disable iff (srst)
    rej_r |-> !burn_wr) else $error("rejected part burned again");
  a_guard_after: assert property (@(posedge clock) disable iff (srst)
    ver_wr |-> burned_r) else $error("guard band used outside programming");
  a_refresh_armed: assert property (@(posedge clock) disable iff (srst)
    ref_wr |-> ver_r) else $error("refresh before guard band set");
  a_poll_bound: assert property (@(posedge clock) disable iff (srst)
    st_r == S_POLL && tmo_r == TW'(BURN_TMO) && req_r && dev_ack
    && dev_rdata != PROG_DONE |=> st_r == S_FAIL && tmo_flag_r)
    else $error("poll timeout not ended");
  a_req_held: assert property (@(posedge clock) disable iff (srst)
    req_r && !dev_ack |=> req_r && $stable(addr_r) && $stable(wd_r))
    else $error("request dropped before acknowledge");

  c_pass: cover property (@(posedge clock) disable iff (srst) st_r == S_DONE);
  c_guard_fail: cover property (@(posedge clock) disable iff (srst)
    $past(st_r) == S_CHK2 && st_r == S_FAIL);
  c_timeout: cover property (@(posedge clock) disable iff (srst) $rose(tmo_flag_r));
  c_second_die: cover property (@(posedge clock) disable iff (srst) $rose(die_r));

endmodule

`default_nettype wire

/* test/sensor_model.sv */
// behavioural sensor: settings image, fuse burn, guard-band refresh, power cycle
`timescale 1ns/1ps
`default_nettype none
module sensor_model
  import otp_seq_pkg::*;
(
  // clock and reset, reset also stands for a fresh unburned part
  input  wire logic        clock,
  input  wire logic        srst,
  // register access port
  input  wire logic        dev_req,
  input  wire logic        dev_we,
  input  wire logic [13:0] dev_addr,
  input  wire logic [7:0]  dev_wdata,
  output logic [15:0]      dev_rdata,
  output logic             dev_ack,
  input  wire logic        die_sel,
  // bench controls: power cycle, latency, magnet, faults (weak, pwrbad, stuck, drop)
  input  wire logic        pwr,
  input  wire logic        slow,
  input  wire logic [13:0] angle,
  input  wire logic [3:0]  fault
);
  logic [7:0] img  [2][7]; // live settings registers per die
  logic [7:0] fuse [2][7]; // burned fuse contents per die
  logic [7:0] prog_r;      // program control register
  logic       guard_r;     // guard-band sensing armed
  int         burns [2];   // burns seen per die
  int         viol;        // host order faults seen
  int         cnt;         // remaining burn time
  int         wt;          // remaining answer delay
  int         ix;          // offset inside the image window

  // key over the settings bytes, protection register excluded
  function automatic logic [7:0] key_of(input int d);
    logic [7:0] k;
    k = 8'h00;
    for (int i = 0; i < 6; i++) k ^= img[d][i];
    return k & ECC_KEY_MASK;
  endfunction

  // one process: the model is sequential by nature and never races the host
  always @(posedge clock) begin
    ix = int'(dev_addr) - int'(DEV_IMG_BASE);
    dev_ack <= 1'b0;
    if (srst) begin
      for (int d = 0; d < 2; d++) begin
        for (int i = 0; i < 7; i++) begin
          img[d][i] = 8'h00;
          fuse[d][i] = 8'h00;
        end
        burns[d] = 0;
      end
      viol = 0;
      cnt = 0;
      wt = 0;
      prog_r = 8'h00;
      guard_r = 1'b0;
      dev_rdata <= 16'h5a5a;
    end else begin
      // burn time runs out, unless the part is stuck
      if (cnt > 0) begin
        cnt--;
        if (cnt == 0 && !fault[2]) prog_r = 8'h01;
      end
      // power cycle reloads from fuses without guard band
      if (pwr) begin
        img[die_sel] = fuse[die_sel];
        img[die_sel][6][0] ^= fault[1];
        guard_r = 1'b0;
        prog_r = 8'h00;
      end
      if (dev_req && !dev_ack && wt > 0) begin
        wt--;
        dev_rdata <= ~dev_rdata;
      end else if (dev_req && !dev_ack) begin
        dev_ack <= 1'b1;
        wt = slow ? 3 : 0;
        if (dev_addr == DEV_PROG) dev_rdata <= {8'h00, prog_r};
        else if (dev_addr == DEV_ANGLE) dev_rdata <= {2'b00, angle};
        else if (dev_addr == DEV_KEY) dev_rdata <= {8'h00, key_of(die_sel)};
        else if (ix >= 0 && ix < 7) dev_rdata <= {8'h00, img[die_sel][ix]};
        else dev_rdata <= 16'h0000;
        // a dropped write leaves config_reg_b untouched
        if (dev_we && ix >= 0 && ix < 7 && !(fault[3] && ix == 4)) img[die_sel][ix] = dev_wdata;
        if (dev_we && dev_addr == DEV_PROG) begin
          if (dev_wdata[PROG_BRN_BIT] && !prog_r[PROG_EN_BIT]) viol++;
          if (dev_wdata[PROG_VER_BIT] && burns[die_sel] == 0) viol++;
          if (dev_wdata[PROG_REF_BIT] && !guard_r) viol++;
          prog_r = dev_wdata;
          if (dev_wdata[PROG_BRN_BIT]) begin
            fuse[die_sel] = img[die_sel];
            burns[die_sel]++;
            cnt = 8;
          end
          if (dev_wdata[PROG_VER_BIT]) guard_r = 1'b1;
          if (dev_wdata[PROG_REF_BIT]) begin
            for (int i = 0; i < 7; i++) if (img[die_sel][i] != 8'h00) viol++;
            img[die_sel] = fuse[die_sel];
            img[die_sel][3][0] ^= guard_r & fault[0];
          end
        end
      end else if (!dev_ack) dev_rdata <= ~dev_rdata; // no stale data between answers
    end
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
// testbench: apb-driven sequence runs against the sensor model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import otp_seq_pkg::*;
  logic        clock = 1'b0;    // 100 MHz
  logic        srst = 1'b1;     // synchronous reset
  logic        psel = 1'b0;     // apb controls
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, dev_req, dev_we, dev_ack, power_cycle_req, die_sel, part_rejected;
  logic [31:0] prdata;
  logic [13:0] dev_addr;
  logic [7:0]  dev_wdata;
  logic [15:0] dev_rdata;
  logic        pwr = 1'b0, slow = 1'b0; // power cycle pulse, slow answers
  logic [13:0] angle = 14'h0;           // magnet position
  logic [3:0]  fault = 4'h0;            // fault modes of the model
  logic [31:0] seed = 32'd78790;        // xorshift state
  int          n_mismatch = 0, n_compared = 0;

  otp_seq_host #(.BURN_TMO(20)) dut (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .dev_req(dev_req), .dev_we(dev_we),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack),
    .power_cycle_req(power_cycle_req), .die_sel(die_sel), .part_rejected(part_rejected));
  sensor_model u_dev (.clock(clock), .srst(srst), .dev_req(dev_req), .dev_we(dev_we),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack),
    .die_sel(die_sel), .pwr(pwr), .slow(slow), .angle(angle), .fault(fault));

  always #5 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // answer latency varies at random
  always @(posedge clock) slow <= ^rnd();

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer; holds everything until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one part through the whole sequence; reference built from integers
  task automatic run(input logic [3:0] f, input logic dual, input logic rst);
    logic [31:0] q, cfg, a;
    logic        er;
    logic [7:0]  e [7];
    int          np, fl, rj;
    if (rst) begin
      @(posedge clock);
      srst <= 1'b1;
      repeat (20) @(posedge clock);
      srst <= 1'b0;
    end
    cfg = (rnd() & 32'h00ffffff) | 32'h00000100; // config_reg_b never zero
    a = rnd() & 32'h3fff;
    fault <= f;
    angle <= a[13:0];
    apb(1'b1, REG_CFG, cfg, q, er);
    apb(1'b0, REG_CFG, 32'h0, q, er);
    chk("cfg", cfg, q);
    apb(1'b1, REG_CTRL, {29'h0, dual, 2'b01}, q, er);
    apb(1'b0, REG_CTRL, 32'h0, q, er);
    chk("ctrl", {29'h0, dual, 2'b00}, q);
    np = 0;
    for (int k = 0; k < 600; k++) begin
      apb(1'b0, REG_STAT, 32'h0, q, er);
      if (q[2] || q[3]) break;
      if (power_cycle_req === 1'b1) begin // power cycle then resume
        pwr <= 1'b1;
        @(posedge clock);
        pwr <= 1'b0;
        np++;
        apb(1'b1, REG_CTRL, 32'h2, q, er);
      end
    end
    fl = (f != 4'h0);
    rj = fl && !f[3];
    chk("status", {28'h0, f[2], rj[0], fl[0], !fl[0]}, {28'h0, q[5:2]});
    chk("state", {27'h0, (fl != 0) ? 5'(S_FAIL) : 5'(S_DONE)}, {q[31:12], 7'h0, q[11:7]});
    chk("die", dual && !fl, {31'h0, q[6]});
    chk("die_sel", dual && !fl, die_sel);
    chk("idle", 0, {30'h0, q[1:0]});
    chk("rejected", rj, part_rejected);
    chk("burns0", !f[3], u_dev.burns[0]);
    chk("burns1", dual && !fl, u_dev.burns[1]);
    chk("power", fl ? (f[1] ? 2 : 1) : (dual ? 4 : 2), np);
    chk("order", 0, u_dev.viol);
    apb(1'b0, REG_ANGLE, 32'h0, q, er);
    chk("angle", a, {18'h0, q[13:0]});
    // expected fuse image: blank first byte, zero angle, settings, key
    e[0] = 8'h00;
    e[1] = a[13:6];
    e[2] = {2'b00, a[5:0]};
    e[3] = cfg[7:0];
    e[4] = cfg[15:8];
    e[5] = cfg[23:16];
    e[6] = 8'h00;
    for (int i = 0; i < 6; i++) e[6] ^= e[i];
    e[6] = (e[6] & 8'h7f) | 8'h80;
    for (int d = 0; d < 2; d++)
      if (!f[3] && (d == 0 || (dual && !fl)))
        for (int i = 0; i < 7; i++) chk("fuse", e[i], u_dev.fuse[d][i]);
    // a rejected part must refuse another start
    if (rj) begin
      apb(1'b1, REG_CTRL, 32'h1, q, er);
      repeat (60) @(posedge clock);
      chk("reburn", 1, u_dev.burns[0]);
      apb(1'b0, REG_STAT, 32'h0, q, er);
      chk("reburn_state", 5'(S_FAIL), {27'h0, q[11:7]});
    end
  endtask

  initial begin
    #800000;
    n_mismatch++;
    final_report();
  end

  initial begin
    logic [31:0] q;
    logic        er;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    apb(1'b0, REG_CFG, 32'h0, q, er);
    chk("cfg_reset", {8'h0, CFG_RST}, q);
    apb(1'b0, 8'h10, 32'h0, q, er);
    chk("unmapped", 1, er);
    chk("pready", 1, pready);
    run(4'h0, 1'b0, 1'b0); // plain pass
    run(4'h0, 1'b1, 1'b1); // two dies
    run(4'h1, 1'b0, 1'b1); // weak fuse under guard band
    run(4'h2, 1'b0, 1'b1); // bad after power cycle
    run(4'h4, 1'b0, 1'b1); // burn never completes
    run(4'h8, 1'b0, 1'b1); // write lost before burn
    run(4'h0, 1'b0, 1'b0); // retry after a non-rejecting fail
    final_report();
  end
endmodule
`default_nettype wire
